// [rtl/at_bus_cycle_pkg.sv]
// Constants and carrier types for the expansion-bus cycle controller
package at_bus_cycle_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_LATCH_DELAY = 10'h000;
	localparam logic [9:0] IDX_LATCH_WIDTH = 10'h001;
	localparam logic [9:0] IDX_NARROW_DELAY = 10'h003;
	localparam logic [9:0] IDX_NARROW_WAIT = 10'h004;
	localparam logic [9:0] IDX_WIDE_IO_WAIT = 10'h005;
	localparam logic [9:0] IDX_WIDE_MEM_DELAY = 10'h006;
	localparam logic [9:0] IDX_WIDE_MEM_WAIT = 10'h007;
	localparam logic [9:0] IDX_MIN_WAIT = 10'h008;
	localparam logic [9:0] IDX_SPEED = 10'h063;
	localparam logic [9:0] IDX_STATUS = 10'h064;

	// Speed-select fields
	localparam int SPEED_CPU_BIT = 2;
	localparam int SPEED_DMA_BIT = 3;

	// Status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WIDE_BIT = 1;
	localparam int ST_EARLY_BIT = 2;
	localparam int ST_RESET_BIT = 3;
	localparam int ST_PEND_BIT = 4;
	localparam int ST_CPUHI_BIT = 5;
	localparam int ST_DMAHI_BIT = 6;

	// Reset values of the timing registers
	localparam logic [3:0] RST_LATCH_DELAY = 4'h2;
	localparam logic [3:0] RST_LATCH_WIDTH = 4'h5;
	localparam logic [3:0] RST_NARROW_DELAY = 4'h9;
	localparam logic [3:0] RST_NARROW_WAIT = 4'hF;
	localparam logic [3:0] RST_WIDE_IO_WAIT = 4'h8;
	localparam logic [3:0] RST_WIDE_MEM_DELAY = 4'h6;
	localparam logic [3:0] RST_WIDE_MEM_WAIT = 4'h8;
	localparam logic [3:0] RST_MIN_WAIT = 4'h5;
	localparam logic [3:0] RST_SPEED = 4'h0;

	// Clock divider and reset pulse counts
	localparam logic [1:0] PROC_HALF_LOW = 2'h1;
	localparam logic [1:0] PROC_HALF_HIGH = 2'h0;
	localparam logic [1:0] DMA_HALF_LOW = 2'h1;
	localparam logic [1:0] DMA_HALF_HIGH = 2'h0;
	localparam logic [2:0] RESET_DMA_PERIODS = 3'h4;

	typedef struct packed {
		logic valid;
		logic isMem;
		logic isIo;
		logic isWrite;
		logic isInta;
		logic isShutdown;
		logic addrLow;
		logic highByte_b;
	} cycle_req_t;

	typedef struct packed {
		logic bale;
		logic memRead_b;
		logic memWrite_b;
		logic ioRead_b;
		logic ioWrite_b;
	} bus_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STATUS,
		ST_RUN
	} cyc_state_t;

endpackage

// [rtl/at_bus_cycle_control.sv]
// Expansion-bus cycle control, clock selection and byte-lane steering
`timescale 1ns/1ps
`default_nettype none

// Function
// - Early finish sampled mid wait state
// - Early finish only after minimum waits
// - Wide memory select only in memory cycles
// - Wide I/O select only in I/O cycles
// - Channel ready sampled each T state end
// - Bus commands change on processor clock fall
// - Speed bit 2 picks processor clock
// - Speed bit 3 picks DMA clock
// - Stretch SYSCLK low while ALE high, processor high speed only
// - Delayed write lags one clock low speed
// - Acknowledge forces byte address low
// - Acknowledge forces low buffer enable
// - High buffer enable tracks bus high enable
// - Shutdown reset lasts four DMA periods
// - Reset starts after DMA divide-by-4 rise
// - Float address low during hold except channel-2 DMA
// - Float external high enable during hold while AEN low
// - Bus high enable low during channel-2 DMA
// - Secondary hold drives processor high enable
// - DMA memory read pulls DMA ready low
module at_bus_cycle_control #(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor cycle request
	input wire at_bus_cycle_pkg::cycle_req_t cycleReq,
	output logic cycleDone,
	// Expansion bus
	output at_bus_cycle_pkg::bus_cmd_t busCmd,
	output logic delayedIoWrite_b,
	input wire logic earlyFinishReq_b,
	input wire logic wideMemorySelect_b,
	input wire logic wideIoSelect_b,
	input wire logic ioChannelReady,
	// Clocks
	output logic processorClockOut,
	output logic dmaClockOut,
	output logic sysClk,
	output logic addrLatchEnable,
	// Byte lanes
	input wire logic interruptAckStrobe_b,
	output logic byteAddressLowOut,
	output logic byteAddressLowOe_b,
	output logic busHighByteEnable_b,
	output logic lowByteBufferEnable_b,
	output logic highByteBufferEnable_b,
	input wire logic extHighByteEnableIn_b,
	output logic extHighByteEnableOut_b,
	output logic extHighByteEnableOe_b,
	output logic procByteHighOut_b,
	output logic procByteHighOe_b,
	// Hold and DMA
	input wire logic holdAck,
	input wire logic secondaryHoldAck,
	input wire logic dmaAckChannelTwo,
	input wire logic addressEnable,
	input wire logic dmaMemoryRead_b,
	output logic dmaReadyOut,
	output logic processorResetPulse
);
	import at_bus_cycle_pkg::*;

	localparam int TW = CNT_W + 1;

	logic [CNT_W-1:0] latchDelayReg_q, latchWidthReg_q, narrowDelayReg_q;
	logic [CNT_W-1:0] narrowWaitReg_q, wideIoWaitReg_q, wideMemDelayReg_q;
	logic [CNT_W-1:0] wideMemWaitReg_q, minWaitReg_q;
	logic [3:0] speedReg_q;
	logic cpuHigh, dmaHigh;
	logic [1:0] procDiv_q, dmaDiv_q, dmaQuarter_q;
	logic procClk_q, dma_clock_out_q, sysClk_q;
	logic procEdge, procFall, procRise, dmaRise, quarterRise;
	cyc_state_t state_q;
	cycle_req_t req_q;
	bus_cmd_t cmd_q;
	logic [TW-1:0] tCnt_q, latchEnd, samplePt, cmdDelay, waitTarget;
	logic [CNT_W-1:0] waitCnt_q;
	logic wideSel_q, wideDone_q, cmdOn_q, earlyHit_q, rdy_q, done_q;
	logic ioWrDly_q, ale_q, cycleEnd;
	logic byte_address_low_q, adr0Oe_b_q, bhe_b_q, low_byte_buffer_enable_b_q, ehbeOe_b_q;
	logic procHbe_b_q, procHbeOe_b_q, dma_ready_out_q;
	logic resetPend_q, quarterSeen_q, processor_reset_pulse_q;
	logic [2:0] resCnt_q;
	logic [9:0] idx;
	logic apbWrite, mapped;

	function automatic logic [TW-1:0] ext(input logic [CNT_W-1:0] v);
		ext = {1'b0, v};
	endfunction

	// Speed selection
	// processor clock choice
	assign cpuHigh = speedReg_q[SPEED_CPU_BIT];
	assign dmaHigh = speedReg_q[SPEED_DMA_BIT];

	// Processor clock divider, both edges exposed as enables
	assign procEdge = ce && (procDiv_q == (cpuHigh ? PROC_HALF_HIGH
		: PROC_HALF_LOW));
	assign procFall = procEdge && procClk_q;
	assign procRise = procEdge && !procClk_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			procDiv_q <= 2'h0;
			procClk_q <= 1'b0;
		end else if (procEdge) begin
			procDiv_q <= 2'h0;
			procClk_q <= !procClk_q;
		end else if (ce) begin
			procDiv_q <= procDiv_q + 2'h1;
		end
	end

	// DMA clock toggles on processor falls only
	assign dmaRise = procFall && !dma_clock_out_q &&
		(dmaDiv_q == (dmaHigh ? DMA_HALF_HIGH : DMA_HALF_LOW));
	assign quarterRise = dmaRise && (dmaQuarter_q == 2'h1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dmaDiv_q <= 2'h0;
			dma_clock_out_q <= 1'b0;
			dmaQuarter_q <= 2'h0;
		end else if (procFall) begin
			if (dmaDiv_q == (dmaHigh ? DMA_HALF_HIGH : DMA_HALF_LOW)) begin
				dmaDiv_q <= 2'h0;
				dma_clock_out_q <= !dma_clock_out_q;
			end else begin
				dmaDiv_q <= dmaDiv_q + 2'h1;
			end
			if (dmaRise) begin
				dmaQuarter_q <= dmaQuarter_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sysClk_q <= 1'b0;
		end else if (procFall && !(cpuHigh && !sysClk_q && ale_q)) begin
			sysClk_q <= !sysClk_q;
		end
	end

	// Cycle timing
	assign latchEnd = TW'(ext(latchDelayReg_q) + ext(latchWidthReg_q));
	// select must settle before the earlier event
	assign samplePt = (ext(wideMemDelayReg_q) < latchEnd) ?
		ext(wideMemDelayReg_q) : latchEnd;
	assign cmdDelay = (req_q.isMem && wideSel_q) ? ext(wideMemDelayReg_q)
		: ext(narrowDelayReg_q);
	always_comb begin
		waitTarget = ext(narrowWaitReg_q);
		if (req_q.isMem && wideSel_q) begin
			waitTarget = ext(wideMemWaitReg_q);
		end else if (req_q.isIo && wideSel_q) begin
			waitTarget = ext(wideIoWaitReg_q);
		end
	end
	// ready taken one fall earlier decides the end
	assign cycleEnd = (cmdOn_q || req_q.isInta) &&
		((ext(waitCnt_q) >= waitTarget && rdy_q) || earlyHit_q);

	// channel ready sampled at each T state end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdy_q <= 1'b1;
		end else if (procFall) begin
			// adapter must be low here a T state early
			rdy_q <= ioChannelReady;
		end
	end

	// Cycle sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			req_q <= '0;
			tCnt_q <= '0;
			waitCnt_q <= '0;
			wideSel_q <= 1'b0;
			wideDone_q <= 1'b0;
			cmdOn_q <= 1'b0;
			ale_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= 1'b0;
			if (procFall) begin
				unique case (state_q)
					ST_IDLE: begin
						if (cycleReq.valid && !done_q) begin
							req_q <= cycleReq;
							tCnt_q <= '0;
							waitCnt_q <= '0;
							wideSel_q <= 1'b0;
							wideDone_q <= 1'b0;
							if (cycleReq.isShutdown) begin
								done_q <= 1'b1;
							end else begin
								ale_q <= 1'b1;
								state_q <= ST_STATUS;
							end
						end
					end
					ST_STATUS: begin
						ale_q <= 1'b0;
						tCnt_q <= TW'(1);
						state_q <= ST_RUN;
					end
					ST_RUN: begin
						if (!(&tCnt_q)) begin
							tCnt_q <= tCnt_q + TW'(1);
						end
						// memory cycles look at wide memory select
						if (!wideDone_q && req_q.isMem && tCnt_q >= samplePt) begin
							wideSel_q <= !wideMemorySelect_b;
							wideDone_q <= 1'b1;
						end
						// I/O cycles look at wide I/O select
						if (!wideDone_q && req_q.isIo &&
							tCnt_q >= ext(narrowDelayReg_q)) begin
							wideSel_q <= !wideIoSelect_b;
							wideDone_q <= 1'b1;
						end
						if (!wideDone_q && !req_q.isMem && !req_q.isIo) begin
							wideDone_q <= 1'b1;
						end
						if (wideDone_q && !cmdOn_q && tCnt_q >= cmdDelay &&
							(req_q.isMem || req_q.isIo)) begin
							cmdOn_q <= 1'b1;
						end
						if ((cmdOn_q || req_q.isInta) && !(&waitCnt_q)) begin
							waitCnt_q <= waitCnt_q + CNT_W'(1);
						end
						if (cycleEnd) begin
							cmdOn_q <= 1'b0;
							done_q <= 1'b1;
							state_q <= ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	// sample early finish at wait-state midpoint
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			earlyHit_q <= 1'b0;
		end else if (procFall && state_q == ST_IDLE) begin
			earlyHit_q <= 1'b0;
		end else if (procRise && cmdOn_q && !earlyFinishReq_b &&
			// not before the minimum wait count
			waitCnt_q >= minWaitReg_q) begin
			earlyHit_q <= 1'b1;
		end
	end

	// bus outputs updated on processor falls
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_q <= '{bale: 1'b0, memRead_b: 1'b1, memWrite_b: 1'b1,
				ioRead_b: 1'b1, ioWrite_b: 1'b1};
			ioWrDly_q <= 1'b1;
		end else if (procFall) begin
			cmd_q.bale <= state_q == ST_RUN &&
				tCnt_q >= ext(latchDelayReg_q) && tCnt_q < latchEnd;
			cmd_q.memRead_b <= !(cmdOn_q && !cycleEnd && req_q.isMem &&
				!req_q.isWrite);
			cmd_q.memWrite_b <= !(cmdOn_q && !cycleEnd && req_q.isMem &&
				req_q.isWrite);
			cmd_q.ioRead_b <= !(cmdOn_q && !cycleEnd && req_q.isIo &&
				!req_q.isWrite);
			cmd_q.ioWrite_b <= !(cmdOn_q && !cycleEnd && req_q.isIo &&
				req_q.isWrite);
			ioWrDly_q <= cmd_q.ioWrite_b;
		end
	end

	// lag the fall at low speed, rise together
	assign delayedIoWrite_b = cmd_q.ioWrite_b || (!cpuHigh && ioWrDly_q);

	// Byte lanes and hold steering
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_address_low_q <= 1'b0;
			adr0Oe_b_q <= 1'b0;
			bhe_b_q <= 1'b1;
			low_byte_buffer_enable_b_q <= 1'b1;
			ehbeOe_b_q <= 1'b0;
			procHbe_b_q <= 1'b1;
			procHbeOe_b_q <= 1'b1;
		end else if (procFall) begin
			if (!interruptAckStrobe_b) begin
				byte_address_low_q <= 1'b0;
			end else if (ale_q) begin
				byte_address_low_q <= req_q.addrLow;
			end
			// channel-2 DMA makes bus high enable low
			if (holdAck && dmaAckChannelTwo && addressEnable) begin
				bhe_b_q <= 1'b0;
			end else if (ale_q) begin
				bhe_b_q <= req_q.highByte_b;
			end
			low_byte_buffer_enable_b_q <= !(!interruptAckStrobe_b ||
				(cmdOn_q && !byte_address_low_q && !cycleEnd));
			// float address low in hold until DMA ch2
			adr0Oe_b_q <= holdAck && !(dmaAckChannelTwo && addressEnable);
			// float external enable in hold until AEN
			ehbeOe_b_q <= holdAck && !addressEnable;
			// follow external enable under secondary hold
			procHbe_b_q <= extHighByteEnableIn_b;
			procHbeOe_b_q <= !secondaryHoldAck;
		end
	end

	// DMA memory read pulls ready low at once
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dma_ready_out_q <= 1'b1;
		end else if (ce) begin
			if (!dmaMemoryRead_b) begin
				dma_ready_out_q <= 1'b0;
			end else if (dmaRise) begin
				dma_ready_out_q <= ioChannelReady;
			end
		end
	end

	// Shutdown reset pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resetPend_q <= 1'b0;
			quarterSeen_q <= 1'b0;
			processor_reset_pulse_q <= 1'b0;
			resCnt_q <= 3'h0;
		end else if (procFall) begin
			if (state_q == ST_IDLE && cycleReq.valid && cycleReq.isShutdown &&
				!done_q) begin
				resetPend_q <= 1'b1;
			end
			if (resetPend_q && quarterRise) begin
				quarterSeen_q <= 1'b1;
			end
			if (quarterSeen_q && !processor_reset_pulse_q) begin
				processor_reset_pulse_q <= 1'b1;
				resCnt_q <= 3'h0;
				resetPend_q <= 1'b0;
				quarterSeen_q <= 1'b0;
			end else if (processor_reset_pulse_q && resCnt_q == RESET_DMA_PERIODS) begin
				// end one fall after fourth rise, same phase as start
				processor_reset_pulse_q <= 1'b0;
			end else if (processor_reset_pulse_q && dmaRise) begin
				resCnt_q <= resCnt_q + 3'h1;
			end
		end
	end

	// APB slave, zero wait states
	assign idx = paddr[11:2];
	assign apbWrite = psel && penable && pwrite && ce;
	always_comb begin
		mapped = 1'b1;
		prdata = 32'h0000_0000;
		unique case (idx)
			IDX_LATCH_DELAY: prdata[CNT_W-1:0] = latchDelayReg_q;
			IDX_LATCH_WIDTH: prdata[CNT_W-1:0] = latchWidthReg_q;
			IDX_NARROW_DELAY: prdata[CNT_W-1:0] = narrowDelayReg_q;
			IDX_NARROW_WAIT: prdata[CNT_W-1:0] = narrowWaitReg_q;
			IDX_WIDE_IO_WAIT: prdata[CNT_W-1:0] = wideIoWaitReg_q;
			IDX_WIDE_MEM_DELAY: prdata[CNT_W-1:0] = wideMemDelayReg_q;
			IDX_WIDE_MEM_WAIT: prdata[CNT_W-1:0] = wideMemWaitReg_q;
			IDX_MIN_WAIT: prdata[CNT_W-1:0] = minWaitReg_q;
			IDX_SPEED: prdata[3:0] = speedReg_q;
			IDX_STATUS: begin
				prdata[ST_BUSY_BIT] = state_q != ST_IDLE;
				prdata[ST_WIDE_BIT] = wideSel_q;
				prdata[ST_EARLY_BIT] = earlyHit_q;
				prdata[ST_RESET_BIT] = processor_reset_pulse_q;
				prdata[ST_PEND_BIT] = resetPend_q;
				prdata[ST_CPUHI_BIT] = cpuHigh;
				prdata[ST_DMAHI_BIT] = dmaHigh;
			end
			default: mapped = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			latchDelayReg_q <= CNT_W'(RST_LATCH_DELAY);
			latchWidthReg_q <= CNT_W'(RST_LATCH_WIDTH);
			narrowDelayReg_q <= CNT_W'(RST_NARROW_DELAY);
			narrowWaitReg_q <= CNT_W'(RST_NARROW_WAIT);
			wideIoWaitReg_q <= CNT_W'(RST_WIDE_IO_WAIT);
			wideMemDelayReg_q <= CNT_W'(RST_WIDE_MEM_DELAY);
			wideMemWaitReg_q <= CNT_W'(RST_WIDE_MEM_WAIT);
			minWaitReg_q <= CNT_W'(RST_MIN_WAIT);
			speedReg_q <= RST_SPEED;
		end else if (apbWrite) begin
			unique case (idx)
				IDX_LATCH_DELAY: latchDelayReg_q <= pwdata[CNT_W-1:0];
				IDX_LATCH_WIDTH: latchWidthReg_q <= pwdata[CNT_W-1:0];
				IDX_NARROW_DELAY: narrowDelayReg_q <= pwdata[CNT_W-1:0];
				IDX_NARROW_WAIT: narrowWaitReg_q <= pwdata[CNT_W-1:0];
				IDX_WIDE_IO_WAIT: wideIoWaitReg_q <= pwdata[CNT_W-1:0];
				IDX_WIDE_MEM_DELAY: wideMemDelayReg_q <= pwdata[CNT_W-1:0];
				IDX_WIDE_MEM_WAIT: wideMemWaitReg_q <= pwdata[CNT_W-1:0];
				IDX_MIN_WAIT: minWaitReg_q <= pwdata[CNT_W-1:0];
				IDX_SPEED: speedReg_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Output wiring
	assign cycleDone = done_q;
	assign busCmd = cmd_q;
	assign processorClockOut = procClk_q;
	assign dmaClockOut = dma_clock_out_q;
	assign sysClk = sysClk_q;
	assign addrLatchEnable = ale_q;
	assign byteAddressLowOut = byte_address_low_q;
	assign byteAddressLowOe_b = adr0Oe_b_q;
	assign busHighByteEnable_b = bhe_b_q;
	assign lowByteBufferEnable_b = low_byte_buffer_enable_b_q;
	// high buffer enable follows bus high enable
	assign highByteBufferEnable_b = bhe_b_q;
	assign extHighByteEnableOut_b = bhe_b_q;
	assign extHighByteEnableOe_b = ehbeOe_b_q;
	assign procByteHighOut_b = procHbe_b_q;
	assign procByteHighOe_b = procHbeOe_b_q;
	assign dmaReadyOut = dma_ready_out_q;
	assign processorResetPulse = processor_reset_pulse_q;

endmodule // at_bus_cycle_control

`default_nettype wire

// [verif/at_bus_cycle_assertions.sv]
// Port-level checks for the expansion-bus cycle controller
`timescale 1ns/1ps
`default_nettype none
module at_bus_cycle_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Observed ports
	input wire at_bus_cycle_pkg::bus_cmd_t busCmd,
	input wire logic processorClockOut,
	input wire logic dmaClockOut,
	input wire logic processorResetPulse,
	input wire logic interruptAckStrobe_b,
	input wire logic byteAddressLowOut,
	input wire logic byteAddressLowOe_b,
	input wire logic busHighByteEnable_b,
	input wire logic lowByteBufferEnable_b,
	input wire logic highByteBufferEnable_b,
	input wire logic extHighByteEnableIn_b,
	input wire logic extHighByteEnableOe_b,
	input wire logic procByteHighOut_b,
	input wire logic procByteHighOe_b,
	input wire logic holdAck,
	input wire logic secondaryHoldAck,
	input wire logic dmaAckChannelTwo,
	input wire logic addressEnable,
	input wire logic dmaMemoryRead_b,
	input wire logic dmaReadyOut
);
	import at_bus_cycle_pkg::*;
	logic [3:0] rises_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// DMA rises seen while the reset pulse stands
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rises_q <= 4'h0;
		else if (!processorResetPulse)
			rises_q <= 4'h0;
		else if ($rose(dmaClockOut))
			rises_q <= rises_q + 4'h1;
	end
	a_cmd_on_fall: assert property (
		$changed(busCmd) |-> $fell(processorClockOut))
		else $error("bus command moved off a processor clock fall");
	a_ack_addr_low: assert property (
		$fell(interruptAckStrobe_b) && !holdAck |-> ##[0:5] !byteAddressLowOut)
		else $error("byte address not forced low on acknowledge");
	a_ack_low_buf: assert property (
		$fell(interruptAckStrobe_b) && !holdAck |->
		##[0:5] !lowByteBufferEnable_b)
		else $error("low buffer enable not forced on acknowledge");
	a_high_buf_track: assert property (
		(!interruptAckStrobe_b && $stable(busHighByteEnable_b))[*8] |->
		highByteBufferEnable_b == busHighByteEnable_b)
		else $error("high buffer enable does not track bus high enable");
	a_reset_width: assert property (
		$fell(processorResetPulse) |-> rises_q == 4'h4)
		else $error("reset pulse width not four DMA periods");
	a_hold_addr_float: assert property (
		(holdAck && !dmaAckChannelTwo)[*8] |-> byteAddressLowOe_b)
		else $error("byte address driven during hold");
	a_hold_external_high_byte_enable_float: assert property (
		(holdAck && !addressEnable)[*8] |-> extHighByteEnableOe_b)
		else $error("external high enable driven during hold");
	a_dma_bhe_low: assert property (
		(holdAck && dmaAckChannelTwo && addressEnable)[*8] |->
		!busHighByteEnable_b)
		else $error("bus high enable not low in channel two DMA");
	a_hold_bhe_follow: assert property (
		(secondaryHoldAck && $stable(extHighByteEnableIn_b))[*8] |->
		!procByteHighOe_b && procByteHighOut_b == extHighByteEnableIn_b)
		else $error("processor high enable does not follow pin");
	a_dma_ready_pull: assert property (
		!dmaMemoryRead_b |=> !dmaReadyOut)
		else $error("DMA ready not pulled low by memory read");
endmodule // at_bus_cycle_assertions
`default_nettype wire

// [verif/at_bus_adapter_model.sv]
// Expansion adapter model: wide selects, ready stretch, early finish
`timescale 1ns/1ps
`default_nettype none
module at_bus_adapter_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bus side
	input wire at_bus_cycle_pkg::bus_cmd_t busCmd,
	output logic ioChannelReady,
	output logic wideMemorySelect_b,
	output logic wideIoSelect_b,
	output logic earlyFinishReq_b,
	// Behaviour
	input wire logic selMem,
	input wire logic selIo,
	input wire logic early,
	input wire logic [7:0] stall
);
	import at_bus_cycle_pkg::*;
	logic cmdLow;
	logic inCyc_q;
	logic cmdPrev_q;
	logic [7:0] hold_q;
	assign cmdLow = ~&busCmd[3:0];
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			inCyc_q <= 1'b0;
			cmdPrev_q <= 1'b0;
			hold_q <= 8'h00;
		end else begin
			cmdPrev_q <= cmdLow;
			if (busCmd.bale)
				inCyc_q <= 1'b1;
			else if (cmdPrev_q && !cmdLow)
				inCyc_q <= 1'b0;
			// ready held low from the command fall
			if (cmdLow && !cmdPrev_q)
				hold_q <= stall;
			else if (hold_q != 8'h00)
				hold_q <= hold_q - 8'h01;
		end
	end
	// Open-collector lines: released means pulled high
	assign ioChannelReady = (hold_q == 8'h00);
	// select valid from the address strobe on
	assign wideMemorySelect_b = !(selMem && (inCyc_q || busCmd.bale));
	assign wideIoSelect_b = !(selIo && (inCyc_q || busCmd.bale));
	assign earlyFinishReq_b = !(early && cmdLow);
endmodule // at_bus_adapter_model
`default_nettype wire

// [verif/at_bus_cycle_control_bench.sv]
// Self-checking bench for the expansion-bus cycle controller
`timescale 1ns/1ps
`default_nettype none
module at_bus_cycle_control_bench;
	import at_bus_cycle_pkg::*;
	logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, cycleDone;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	cycle_req_t cycleReq;
	bus_cmd_t busCmd;
	logic delayedIoWrite_b, earlyFinishReq_b, wideMemorySelect_b;
	logic wideIoSelect_b, ioChannelReady, processorClockOut, dmaClockOut;
	logic sysClk, addrLatchEnable, interruptAckStrobe_b, byteAddressLowOut;
	logic byteAddressLowOe_b, busHighByteEnable_b, lowByteBufferEnable_b;
	logic highByteBufferEnable_b, extHighByteEnableIn_b, extDrv;
	logic extHighByteEnableOut_b, extHighByteEnableOe_b, procByteHighOut_b;
	logic procByteHighOe_b, holdAck, secondaryHoldAck, dmaAckChannelTwo;
	logic addressEnable, dmaMemoryRead_b, dmaReadyOut, processorResetPulse;
	logic selMem, selIo, early;
	logic [7:0] stall;
	logic [3:0] seenLow_q;
	logic [32:0] expQ[$], mskQ[$];
	string nameQ[$];
	int n_mismatch, checks, nA, nB, p, q, s;
	integer seed = 32'hEFE84C58;
	logic [9:0] idxT [8] = '{IDX_LATCH_DELAY, IDX_LATCH_WIDTH,
		IDX_NARROW_DELAY, IDX_NARROW_WAIT, IDX_WIDE_IO_WAIT,
		IDX_WIDE_MEM_DELAY, IDX_WIDE_MEM_WAIT, IDX_MIN_WAIT};
	logic [3:0] rstT [8] = '{RST_LATCH_DELAY, RST_LATCH_WIDTH,
		RST_NARROW_DELAY, RST_NARROW_WAIT, RST_WIDE_IO_WAIT,
		RST_WIDE_MEM_DELAY, RST_WIDE_MEM_WAIT, RST_MIN_WAIT};
	// Two-way pin level from both drivers
	assign extHighByteEnableIn_b = extHighByteEnableOe_b ? extDrv :
		extHighByteEnableOut_b;
	at_bus_cycle_control dut_u (.*);
	at_bus_adapter_model adapter_u (.*);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task report_and_stop;
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input string nm, input logic [32:0] seen, input logic [32:0] e);
		checks++;
		if (seen !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task note(input string nm, input logic [32:0] e, input logic [32:0] m);
		nameQ.push_back(nm);
		expQ.push_back(e);
		mskQ.push_back(m);
	endtask
	task take(input logic [32:0] seen);
		if (expQ.size() == 0) begin
			n_mismatch++;
			$display("mismatch unexpected expected none seen %h", seen);
		end else
			check(nameQ.pop_front(), seen & mskQ.pop_front(), expQ.pop_front());
	endtask
	// Result watcher: read data and finished bus cycles
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite)
			take({pslverr, prdata});
		if (cycleDone === 1'b1)
			take({29'h0, seenLow_q});
		seenLow_q <= (cycleDone || !rst_b) ? 4'h0 : seenLow_q | ~busCmd[3:0];
	end
	task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input string nm, input logic [9:0] i, input logic [32:0] e,
		input logic [32:0] m);
		note(nm, e, m);
		apb(1'b0, i, 32'h0);
	endtask
	task run(input logic [7:0] r, input logic [3:0] e, input logic [3:0] m,
		output int n);
		note("commands", {29'h0, e}, {29'h0, m});
		cycleReq <= cycle_req_t'(r);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cycleDone !== 1'b1 && n < 3000);
		cycleReq <= '0;
		@(posedge clk);
		if (n >= 3000)
			n_mismatch++;
	endtask
	task meas(input logic sel, output int per);
		logic prev, cur;
		int k;
		k = 0;
		per = 0;
		prev = 1'b1;
		for (int i = 0; i < 400 && k < 3; i++) begin
			@(posedge clk);
			per++;
			cur = sel ? dmaClockOut : processorClockOut;
			if (cur && !prev) begin
				k++;
				if (k < 3)
					per = 0;
			end
			prev = cur;
		end
	endtask
	initial begin
		{rst_b, psel, penable, pwrite, holdAck, secondaryHoldAck} = '0;
		{dmaAckChannelTwo, addressEnable, selMem, selIo, early, extDrv} = '0;
		{paddr, pwdata, cycleReq, stall} = '0;
		{ce, interruptAckStrobe_b, dmaMemoryRead_b} = 3'b111;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++)
			rd("timing reset", idxT[i], {29'h0, rstT[i]}, '1);
		rd("unmapped", 10'h0FF, {1'b1, 32'h0}, '1);
		for (s = 3; s >= 0; s--) begin
			apb(1'b1, IDX_SPEED, s << 2);
			rd("speed", IDX_SPEED, s << 2, 33'hC);
			meas(1'b0, p);
			check("cpu period", p, s[0] ? 2 : 4);
			meas(1'b1, q);
			check("dma period", q, p * (s[1] ? 2 : 4));
		end
		rd("no reset", IDX_STATUS, 33'h0, 33'h18);
		run(8'hC0, 4'h8, 4'hF, nA);
		selMem <= 1'b1;
		run(8'hC0, 4'h8, 4'hF, nB);
		rd("wide", IDX_STATUS, 33'h2, 33'h2);
		run(8'hA0, 4'h2, 4'hF, nB);
		rd("wide", IDX_STATUS, 33'h0, 33'h2);
		{selMem, selIo, stall} <= {2'b01, 8'd40};
		run(8'hA0, 4'h2, 4'hF, nB);
		rd("wide", IDX_STATUS, 33'h2, 33'h2);
		stall <= '0;
		run(8'hA0, 4'h2, 4'hF, p);
		check("ready stretch", nB > p + 8, 1'b1);
		early <= 1'b1;
		run(8'hC0, 4'h8, 4'hF, nB);
		rd("early", IDX_STATUS, 33'h4, 33'h4);
		check("early shorter", nB < nA, 1'b1);
		apb(1'b1, IDX_MIN_WAIT, 32'hF);
		run(8'hC0, 4'h8, 4'hF, nB);
		check("early held off", nB, nA);
		apb(1'b1, IDX_MIN_WAIT, RST_MIN_WAIT);
		ce <= 1'b0;
		apb(1'b1, IDX_MIN_WAIT, 32'h0);
		ce <= 1'b1;
		rd("ce hold", IDX_MIN_WAIT, RST_MIN_WAIT, '1);
		early <= 1'b0;
		fork
			run(8'hB0, 4'h1, 4'hF, nB);
			begin
				do @(posedge clk); while (busCmd.ioWrite_b !== 1'b0);
				p = 0;
				do begin
					@(posedge clk);
					p++;
				end while (delayedIoWrite_b !== 1'b0 && p < 50);
				check("write lag", p, 4);
				while (busCmd.ioWrite_b !== 1'b1) @(posedge clk);
				check("write rise", delayedIoWrite_b, 1'b1);
			end
		join
		fork
			run(8'h88, 4'h0, 4'h0, nB);
			begin
				repeat (16) @(posedge clk);
				interruptAckStrobe_b <= 1'b0;
			end
		join
		interruptAckStrobe_b <= 1'b1;
		run(8'h84, 4'h0, 4'hF, nB);
		for (p = 0; processorResetPulse !== 1'b1 && p < 200; p++)
			@(posedge clk);
		check("reset start", p < 200, 1'b1);
		for (q = 0; processorResetPulse === 1'b1 && q < 500; q++)
			@(posedge clk);
		check("reset width", q, 64);
		holdAck <= 1'b1;
		repeat (10) @(posedge clk);
		check("adr float", byteAddressLowOe_b, 1'b1);
		check("external_high_byte_enable float", extHighByteEnableOe_b, 1'b1);
		for (int i = 0; i < 2; i++) begin
			secondaryHoldAck <= 1'b1;
			extDrv <= 1'($random(seed));
			repeat (10) @(posedge clk);
			check("bhe follow", {procByteHighOe_b, procByteHighOut_b},
				{1'b0, extDrv});
		end
		{addressEnable, dmaAckChannelTwo, dmaMemoryRead_b} <= 3'b110;
		repeat (10) @(posedge clk);
		check("adr driven", byteAddressLowOe_b, 1'b0);
		check("external_high_byte_enable driven", extHighByteEnableOe_b, 1'b0);
		check("bus bhe", busHighByteEnable_b, 1'b0);
		check("dma ready", dmaReadyOut, 1'b0);
		{holdAck, secondaryHoldAck, addressEnable, dmaAckChannelTwo} <= '0;
		dmaMemoryRead_b <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			apb(1'b1, idxT[i], v);
			rd("timing", idxT[i], {29'h0, v[3:0]}, '1);
		end
		apb(1'b1, IDX_STATUS, 32'hFFFFFFFF);
		rd("status ro", IDX_STATUS, 33'h0, 33'h1F0);
		report_and_stop();
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end
endmodule // at_bus_cycle_control_bench
bind at_bus_cycle_control at_bus_cycle_assertions chk_u (.*);
`default_nettype wire
